// ==== hdl/uef_defs.vh ====
// Purpose: Constants of the endpoint FIFO allocation block
// Assumes: Included by bare name from the allocation module only; the FIFO does not include it
// Notes: Definitions only
`ifndef UEF_DEFS_VH
`define UEF_DEFS_VH

// --------------------------------------------------------------
// Sizes
// --------------------------------------------------------------
`define UEF_NUM_EP 6
`define UEF_MEM_BYTES 1024
`define UEF_MEM_AW 10
`define UEF_RXQ_DEPTH 4
`define UEF_RXQ_WIDTH 12

// --------------------------------------------------------------
// Register offsets (byte addresses)
// --------------------------------------------------------------
`define UEF_OFF_SEL 8'h00
`define UEF_OFF_CFG 8'h04
`define UEF_OFF_STAT 8'h08
`define UEF_OFF_DATA 8'h0c
`define UEF_OFF_CMD 8'h10
`define UEF_OFF_ERR 8'h14

// --------------------------------------------------------------
// Field positions and codes
// --------------------------------------------------------------
`define UEF_CFG_ISO 0
`define UEF_CFG_DIR_LO 1
`define UEF_CFG_DIR_HI 2
`define UEF_CFG_DBL 3
`define UEF_CFG_INSZ_LO 4
`define UEF_CFG_INSZ_HI 13
`define UEF_CMD_REL 0
`define UEF_CMD_COMMIT 1
`define UEF_ERR_DROP 0
`define UEF_ERR_OVF 1
`define UEF_ERR_UNF 2
`define UEF_DIR_OFF 2'h0
`define UEF_DIR_OUT 2'h1
`define UEF_DIR_IN 2'h2
`define UEF_DIR_BOTH 2'h3

// --------------------------------------------------------------
// Per-endpoint allowance and base in buffer memory
// --------------------------------------------------------------
`define UEF_EP0_MAX 10'h020
`define UEF_EP1_MAX 10'h020
`define UEF_EP2_MAX 10'h040
`define UEF_EP3_MAX 10'h080
`define UEF_EP4_MAX 10'h100
`define UEF_EP5_MAX 10'h200
`define UEF_EP0_BASE 10'h000
`define UEF_EP1_BASE 10'h020
`define UEF_EP2_BASE 10'h040
`define UEF_EP3_BASE 10'h080
`define UEF_EP4_BASE 10'h100
`define UEF_EP5_BASE 10'h200

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define UEF_CFG_RST 14'h0000
`define UEF_EP0_CFG_RST 14'h0106
`define UEF_EP0_FIXED 4'h6

`endif

// ==== hdl/uef_fifo.v ====
// Purpose: Small valid/ready FIFO on the receive path
// Assumes: Depth is a power of two
// Notes: Output data read from the storage flops
`timescale 1ns/10ps
`default_nettype none
module uef_fifo #(
  parameter W = 12,
  parameter D = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  localparam [AW:0] DEPTH = D[AW:0];
  localparam [AW:0] LAST_W = DEPTH - 1'b1;
  localparam [AW-1:0] LAST = LAST_W[AW-1:0];
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] cnt;
  wire push;
  wire pop;

  assign in_ready = (cnt != DEPTH);
  assign out_valid = (cnt != {(AW+1){1'b0}});
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp <= (wp == LAST) ? {AW{1'b0}} : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == LAST) ? {AW{1'b0}} : rp + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule // uef_fifo
`default_nettype wire

// ==== hdl/uef_ep_alloc.v ====
// Purpose: Endpoint buffer allocation of a full-speed USB device
// Assumes: Link side (packet engine) runs on CORE_CLK; APB slave
// Notes: One shared byte memory, one access per cycle
//
// Contract
// - Acts as full-speed USB 2.0 peripheral function
// - Packet buffers in dedicated 1 KB memory
// - Endpoint zero plus endpoints one to five
// - Endpoints 1-5 bulk/interrupt or isochronous type
// - Endpoints OUT only, IN only, or both (endpoint 0 is fixed to both here)
// - Optional double buffering, two packets per direction
// - Endpoint 0 and 1 at most 32 bytes
// - Endpoint 2 64 bytes, endpoint 3 128 bytes
// - Endpoint 4 256 bytes, endpoint 5 512 bytes
// - Bidirectional allowance split IN/OUT by software
`timescale 1ns/10ps
`default_nettype none
`include "uef_defs.vh"
module uef_ep_alloc (
  input wire CORE_CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire RX_VALID,
  output wire RX_READY,
  input wire [2:0] RX_EP,
  input wire [7:0] RX_DATA,
  input wire RX_LAST,
  input wire TX_REQ,
  output wire TX_READY,
  input wire [2:0] TX_EP,
  input wire TX_LAST,
  output reg TX_VALID,
  output reg [7:0] TX_DATA
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  reg [7:0] mem [0:`UEF_MEM_BYTES-1];
  reg [13:0] cfg [0:`UEF_NUM_EP-1];
  reg [9:0] out_wp [0:`UEF_NUM_EP-1];
  reg [9:0] out_rp [0:`UEF_NUM_EP-1];
  reg [9:0] out_cnt [0:`UEF_NUM_EP-1];
  reg [1:0] out_pkts [0:`UEF_NUM_EP-1];
  reg [9:0] in_wp [0:`UEF_NUM_EP-1];
  reg [9:0] in_rp [0:`UEF_NUM_EP-1];
  reg [9:0] in_cnt [0:`UEF_NUM_EP-1];
  reg [1:0] in_pkts [0:`UEF_NUM_EP-1];
  reg [2:0] ep_sel;
  reg [2:0] err;
  integer i;

  function [9:0] ep_max;
    input [2:0] e;
    begin
      case (e)
        3'h0: ep_max = `UEF_EP0_MAX;
        3'h1: ep_max = `UEF_EP1_MAX;
        3'h2: ep_max = `UEF_EP2_MAX;
        3'h3: ep_max = `UEF_EP3_MAX;
        3'h4: ep_max = `UEF_EP4_MAX;
        default: ep_max = `UEF_EP5_MAX;
      endcase
    end
  endfunction

  function [9:0] ep_base;
    input [2:0] e;
    begin
      case (e)
        3'h0: ep_base = `UEF_EP0_BASE;
        3'h1: ep_base = `UEF_EP1_BASE;
        3'h2: ep_base = `UEF_EP2_BASE;
        3'h3: ep_base = `UEF_EP3_BASE;
        3'h4: ep_base = `UEF_EP4_BASE;
        default: ep_base = `UEF_EP5_BASE;
      endcase
    end
  endfunction

  function [9:0] wrap_inc;
    input [9:0] p;
    input [9:0] sz;
    begin
      wrap_inc = (p + 10'h001 >= sz) ? 10'h000 : p + 10'h001;
    end
  endfunction

  // ------------------------------------------------------------
  // Per-endpoint allowance
  // ------------------------------------------------------------
  wire [5:0] can_in;
  wire [5:0] can_out;
  wire [1:0] lim [0:`UEF_NUM_EP-1];
  wire [9:0] in_sz [0:`UEF_NUM_EP-1];
  wire [9:0] out_sz [0:`UEF_NUM_EP-1];
  wire [9:0] in_base [0:`UEF_NUM_EP-1];
  wire [9:0] out_base [0:`UEF_NUM_EP-1];

  genvar g;
  generate
    for (g = 0; g < `UEF_NUM_EP; g = g + 1) begin : g_ep
      localparam integer EPI = g;
      wire [1:0] dir = cfg[g][`UEF_CFG_DIR_HI:`UEF_CFG_DIR_LO];
      wire [9:0] req = cfg[g][`UEF_CFG_INSZ_HI:`UEF_CFG_INSZ_LO];
      wire [9:0] mx = ep_max(EPI[2:0]);
      assign can_in[g] = dir[1];
      assign can_out[g] = dir[0];
      assign lim[g] = cfg[g][`UEF_CFG_DBL] ? 2'h2 : 2'h1;
      // Request above the allowance is clamped, never spills over
      assign in_sz[g] = !dir[1] ? 10'h000 : !dir[0] ? mx : ((req > mx) ? mx : req);
      assign out_sz[g] = dir[0] ? mx - in_sz[g] : 10'h000;
      assign in_base[g] = ep_base(EPI[2:0]);
      assign out_base[g] = ep_base(EPI[2:0]) + in_sz[g];
    end
  endgenerate

  // ------------------------------------------------------------
  // Receive queue from the packet engine
  // ------------------------------------------------------------
  wire [11:0] q_data;
  wire q_valid;
  wire q_ready;

  uef_fifo #(.W(`UEF_RXQ_WIDTH), .D(`UEF_RXQ_DEPTH), .AW(2)) u_rxq (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .in_valid(RX_VALID),
    .in_ready(RX_READY),
    .in_data({RX_LAST, RX_EP, RX_DATA}),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  wire [2:0] rx_ep = q_data[10:8];
  wire rx_last = q_data[11];
  wire rx_ep_ok = (rx_ep < 3'h6);
  wire [2:0] rx_idx = rx_ep_ok ? rx_ep : 3'h0;
  wire rx_drop = !rx_ep_ok || !can_out[rx_idx];
  wire rx_room = (out_cnt[rx_idx] < out_sz[rx_idx]) && (out_pkts[rx_idx] < lim[rx_idx]);

  // ------------------------------------------------------------
  // Transmit side and memory port arbitration
  // ------------------------------------------------------------
  wire tx_ep_ok = (TX_EP < 3'h6);
  wire [2:0] tx_idx = tx_ep_ok ? TX_EP : 3'h0;
  // Host read of an IN packet only once software has committed one
  wire tx_fire = TX_REQ && tx_ep_ok && can_in[tx_idx] && (in_pkts[tx_idx] != 2'h0)
                 && (in_cnt[tx_idx] != 10'h000);
  wire drain_fire = q_valid && !rx_drop && rx_room && !tx_fire;
  // Full endpoint stalls the queue; a stray endpoint is dropped
  assign q_ready = rx_drop || (rx_room && !tx_fire);
  assign TX_READY = tx_fire;

  wire [9:0] out_wa = out_base[rx_idx] + out_wp[rx_idx];
  wire [9:0] in_ra = in_base[tx_idx] + in_rp[tx_idx];

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire acc = PSEL && PENABLE && !PREADY;
  wire is_data = (PADDR == `UEF_OFF_DATA);
  // Link traffic owns the memory port; the CPU waits for a gap
  wire go = acc && !(is_data && (tx_fire || drain_fire));
  wire sel_ok = (ep_sel < 3'h6);
  wire [2:0] s = sel_ok ? ep_sel : 3'h0;
  wire cpu_rd = go && !PWRITE && is_data && sel_ok;
  wire cpu_wr = go && PWRITE && is_data && sel_ok;
  wire rd_ok = cpu_rd && can_out[s] && (out_cnt[s] != 10'h000);
  wire wr_ok = cpu_wr && can_in[s] && (in_cnt[s] < in_sz[s]) && (in_pkts[s] < lim[s]);
  wire cmd_wr = go && PWRITE && (PADDR == `UEF_OFF_CMD) && sel_ok;
  wire rel = cmd_wr && PWDATA[`UEF_CMD_REL] && (out_pkts[s] != 2'h0);
  wire commit = cmd_wr && PWDATA[`UEF_CMD_COMMIT] && can_in[s] && (in_pkts[s] < lim[s]);
  wire cfg_wr = go && PWRITE && (PADDR == `UEF_OFF_CFG) && sel_ok;
  wire [9:0] out_ra = out_base[s] + out_rp[s];
  wire [9:0] in_wa = in_base[s] + in_wp[s];
  wire mapped = (PADDR == `UEF_OFF_SEL) || (PADDR == `UEF_OFF_CFG) || (PADDR == `UEF_OFF_STAT)
                || is_data || (PADDR == `UEF_OFF_CMD) || (PADDR == `UEF_OFF_ERR);
  wire [2:0] err_set = {cpu_rd && !rd_ok, cpu_wr && !wr_ok, q_valid && rx_drop};
  wire [2:0] err_clr = (go && PWRITE && (PADDR == `UEF_OFF_ERR)) ? PWDATA[2:0] : 3'h0;

  // ------------------------------------------------------------
  // Buffer memory
  // ------------------------------------------------------------
  always @(posedge CORE_CLK) begin
    if (drain_fire) begin
      mem[out_wa] <= q_data[7:0];
    end else if (wr_ok) begin
      mem[in_wa] <= PWDATA[7:0];
    end
  end

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      TX_VALID <= 1'b0;
      TX_DATA <= 8'h00;
    end else begin
      TX_VALID <= tx_fire;
      if (tx_fire) begin
        TX_DATA <= mem[in_ra];
      end
    end
  end

  // ------------------------------------------------------------
  // Endpoint pointers and packet counts
  // ------------------------------------------------------------
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      for (i = 0; i < `UEF_NUM_EP; i = i + 1) begin
        cfg[i] <= (i == 0) ? `UEF_EP0_CFG_RST : `UEF_CFG_RST;
        out_wp[i] <= 10'h000;
        out_rp[i] <= 10'h000;
        out_cnt[i] <= 10'h000;
        out_pkts[i] <= 2'h0;
        in_wp[i] <= 10'h000;
        in_rp[i] <= 10'h000;
        in_cnt[i] <= 10'h000;
        in_pkts[i] <= 2'h0;
      end
    end else begin
      for (i = 0; i < `UEF_NUM_EP; i = i + 1) begin
        if (cfg_wr && (s == i)) begin
          // Reconfiguring flushes the endpoint: old offsets are void
          if (i == 0) begin
            cfg[i] <= {PWDATA[`UEF_CFG_INSZ_HI:`UEF_CFG_INSZ_LO], `UEF_EP0_FIXED};
          end else begin
            cfg[i] <= PWDATA[13:0];
          end
          out_wp[i] <= 10'h000;
          out_rp[i] <= 10'h000;
          out_cnt[i] <= 10'h000;
          out_pkts[i] <= 2'h0;
          in_wp[i] <= 10'h000;
          in_rp[i] <= 10'h000;
          in_cnt[i] <= 10'h000;
          in_pkts[i] <= 2'h0;
        end else begin
          if (drain_fire && (rx_idx == i)) begin
            out_wp[i] <= wrap_inc(out_wp[i], out_sz[i]);
            out_cnt[i] <= out_cnt[i] + 10'h001;
          end else if (rd_ok && (s == i)) begin
            out_rp[i] <= wrap_inc(out_rp[i], out_sz[i]);
            out_cnt[i] <= out_cnt[i] - 10'h001;
          end
          out_pkts[i] <= out_pkts[i] + {1'b0, drain_fire && rx_last && (rx_idx == i)}
                         - {1'b0, rel && (s == i)};
          if (wr_ok && (s == i)) begin
            in_wp[i] <= wrap_inc(in_wp[i], in_sz[i]);
            in_cnt[i] <= in_cnt[i] + 10'h001;
          end else if (tx_fire && (tx_idx == i)) begin
            in_rp[i] <= wrap_inc(in_rp[i], in_sz[i]);
            in_cnt[i] <= in_cnt[i] - 10'h001;
          end
          in_pkts[i] <= in_pkts[i] + {1'b0, commit && (s == i)}
                        - {1'b0, tx_fire && TX_LAST && (tx_idx == i)};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // APB slave registers
  // ------------------------------------------------------------
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
      ep_sel <= 3'h0;
      err <= 3'h0;
    end else begin
      // Set wins over a simultaneous clear
      err <= (err & ~err_clr) | err_set;
      PREADY <= go;
      if (go) begin
        PSLVERR <= !mapped;
        if (PWRITE && (PADDR == `UEF_OFF_SEL)) begin
          ep_sel <= PWDATA[2:0];
        end
        case (PADDR)
          `UEF_OFF_SEL: PRDATA <= {29'h0, ep_sel};
          `UEF_OFF_CFG: PRDATA <= sel_ok ? {6'h0, out_sz[s], 2'h0, cfg[s]} : 32'h00000000;
          `UEF_OFF_STAT: PRDATA <= sel_ok ? {2'h0, in_pkts[s], 2'h0, in_cnt[s], 2'h0,
                                            out_pkts[s], 2'h0, out_cnt[s]} : 32'h00000000;
          `UEF_OFF_DATA: PRDATA <= rd_ok ? {24'h0, mem[out_ra]} : 32'h00000000;
          `UEF_OFF_ERR: PRDATA <= {29'h0, err};
          default: PRDATA <= 32'h00000000;
        endcase
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

endmodule // uef_ep_alloc
`default_nettype wire

// ==== verif/uef_alloc_asserts.sv ====
// Purpose: Port assertions of the endpoint allocation block
// Assumes: Bound to uef_ep_alloc
// Notes: DATA accesses may wait, so the answer bound skips them
`timescale 1ns/10ps
`default_nettype none
module uef_alloc_asserts (
  input wire CORE_CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire [7:0] PADDR,
  input wire PREADY,
  input wire PSLVERR,
  input wire RX_VALID,
  input wire RX_READY,
  input wire TX_REQ,
  input wire TX_READY,
  input wire TX_VALID,
  input wire [7:0] TX_DATA
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  wire acc = PSEL && PENABLE && !PREADY;
  property p_ans; acc && PADDR != 8'h0c |=> PREADY; endproperty
  a_ans: assert property (p_ans) else $error("access not answered");
  property p_one; PREADY |=> !PREADY; endproperty
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  property p_cause; PREADY |-> $past(PSEL && PENABLE); endproperty
  a_cause: assert property (p_cause) else $error("ready without access");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err) else $error("error outside answer");
  property p_unm; acc && PADDR > 8'h14 |=> PSLVERR; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not refused");
  property p_map; acc && PADDR < 8'h15 && PADDR[1:0] == 2'h0 |=> !PSLVERR; endproperty
  a_map: assert property (p_map) else $error("mapped refused");
  property p_txv; TX_REQ && TX_READY |=> TX_VALID; endproperty
  a_txv: assert property (p_txv) else $error("taken byte not sent");
  property p_txc; TX_VALID |-> $past(TX_REQ && TX_READY); endproperty
  a_txc: assert property (p_txc) else $error("byte without request");
  property p_txd; !(TX_REQ && TX_READY) |=> $stable(TX_DATA); endproperty
  a_txd: assert property (p_txd) else $error("byte changed unasked");
  property p_rxr; !RX_VALID && RX_READY |=> RX_READY; endproperty
  a_rxr: assert property (p_rxr) else $error("fifo filled without push");
endmodule // uef_alloc_asserts
bind uef_ep_alloc uef_alloc_asserts u_uef_alloc_asserts (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_VALID(RX_VALID),
  .RX_READY(RX_READY), .TX_REQ(TX_REQ), .TX_READY(TX_READY),
  .TX_VALID(TX_VALID), .TX_DATA(TX_DATA)
);
`default_nettype wire

// ==== verif/uef_link_model.sv ====
// Purpose: Packet engine model on the link side
// Assumes: Same clock as the block
// Notes: Released rx_data and tx_ep show inverted values; rx_ep, rx_last and tx_last keep theirs
`timescale 1ns/10ps
`default_nettype none
module uef_link_model (
  input wire logic clk,
  input wire logic rx_ready,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [2:0] rx_ep,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic tx_req,
  output logic [2:0] tx_ep,
  output logic tx_last
);
  // ----------------------------------------
  // Handshakes
  // ----------------------------------------
  logic [7:0] got[$];
  initial {rx_valid, rx_ep, rx_data, rx_last, tx_req, tx_ep, tx_last} = '0;
  always @(posedge clk) begin
    if (tx_valid === 1'b1) got.push_back(tx_data);
  end
  // Ready taken at the rising edge that completes the handshake
  task automatic hs(input logic tx, input int lim, output logic r);
    int w;
    w = 0;
    do begin
      @(posedge clk);
      r = tx ? tx_ready : rx_ready;
      w++;
    end while (r !== 1'b1 && w < lim);
  endtask
  task automatic send(input logic [2:0] ep, input logic [7:0] b, input int n,
      input int lim, output int k);
    logic r;
    k = 0;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_ep <= ep;
      rx_data <= b + i[7:0];
      rx_last <= (i == n - 1);
      hs(1'b0, lim, r);
      if (r !== 1'b1) break;
      k++;
    end
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask
  task automatic pull(input logic [2:0] ep, input int n, input int gap, output int k);
    logic r;
    k = 0;
    repeat (gap + 1) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      tx_req <= 1'b1;
      tx_ep <= ep;
      tx_last <= (i == n - 1);
      hs(1'b1, 50, r);
      if (r !== 1'b1) break;
      k++;
    end
    tx_req <= 1'b0;
    tx_ep <= ~tx_ep;
  endtask
endmodule // uef_link_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench of the endpoint allocation block
// Assumes: APB master tasks, link model on the far side
// Notes: Fixed seed, random configurations and bytes
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic CORE_CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, rd, w;
  logic er;
  logic [7:0] q[$];
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, RX_VALID, RX_READY, RX_LAST, TX_REQ, TX_READY, TX_LAST, TX_VALID;
  wire [2:0] RX_EP, TX_EP;
  wire [7:0] RX_DATA, TX_DATA;
  int error_cnt = 0, num_checks = 0, seed = 32'hd95e, ep, k, k2;
  always #10 CORE_CLK = ~CORE_CLK;
  uef_ep_alloc u_uef_ep_alloc (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_VALID(RX_VALID),
    .RX_READY(RX_READY), .RX_EP(RX_EP), .RX_DATA(RX_DATA), .RX_LAST(RX_LAST),
    .TX_REQ(TX_REQ), .TX_READY(TX_READY), .TX_EP(TX_EP), .TX_LAST(TX_LAST),
    .TX_VALID(TX_VALID), .TX_DATA(TX_DATA));
  uef_link_model u_uef_link_model (.clk(CORE_CLK), .rx_ready(RX_READY),
    .tx_ready(TX_READY), .tx_valid(TX_VALID), .tx_data(TX_DATA), .rx_valid(RX_VALID),
    .rx_ep(RX_EP), .rx_data(RX_DATA), .rx_last(RX_LAST), .tx_req(TX_REQ),
    .tx_ep(TX_EP), .tx_last(TX_LAST));
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic r;
    n = 0;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      r = PREADY;
      n++;
    end while (r !== 1'b1 && n < 200);
    rd = PRDATA;
    er = PSLVERR;
    chk("pready", 32'h1, {31'h0, r});
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rdk(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
    chk("pslverr", {31'h0, a > 8'h14}, {31'h0, er});
  endtask
  function automatic logic [31:0] ecfg(input int e, input logic [31:0] v);
    logic [9:0] m, i;
    logic [3:0] lo;
    m = 10'(32 << ((e > 1) ? e - 1 : 0));
    lo = (e == 0) ? 4'h6 : v[3:0];
    i = (lo[2:1] == 2'h3) ? ((v[13:4] < m) ? v[13:4] : m) : (lo[2:1] == 2'h2) ? m : 10'h0;
    return {6'h0, m - i, 2'h0, v[13:4], lo};
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    rdk(8'h04, 32'h0010_0106, "cfg0");
    rdk(8'h08, 32'h0, "stat0");
    rdk(8'h18, 32'h0, "unmapped");
    rdk(8'hfc, 32'h0, "unmapped");
    $display("test reset done");
    for (int j = 0; j < 24; j++) begin
      ep = (j < 6) ? j : ($unsigned($random(seed)) % 5) + 1;
      w = (j < 6) ? 32'h3ff9 : $random(seed);
      w[2:1] = (j < 6) ? 2'h3 : 2'h1 + 2'($unsigned($random(seed)) % 3);
      apb(1'b1, 8'h00, ep);
      apb(1'b1, 8'h04, w);
      rdk(8'h04, ecfg(ep, w), "cfg");
    end
    apb(1'b1, 8'h00, 32'h6);
    rdk(8'h04, 32'h0, "cfg6");
    $display("test config done");
    // IN-only double buffered endpoint, link stalls before pulling
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h04, 32'h000c);
    for (int i = 0; i < 5; i++) begin
      q.push_back(8'($random(seed)));
      apb(1'b1, 8'h0c, {24'h0, q[i]});
    end
    apb(1'b1, 8'h10, 32'h2);
    rdk(8'h08, 32'h1005_0000, "stat_in");
    u_uef_link_model.pull(3'h3, 5, 6, k);
    chk("pulled", 32'h5, k);
    // Last byte shows on the link one cycle after its request is taken
    repeat (2) @(posedge CORE_CLK);
    chk("txcount", 32'h5, u_uef_link_model.got.size());
    foreach (q[i]) chk("txbyte", {24'h0, q[i]}, {24'h0, u_uef_link_model.got[i]});
    u_uef_link_model.pull(3'h3, 1, 0, k);
    chk("pull_empty", 32'h0, k);
    $display("test in done");
    // OUT-only double buffered: a third packet must stall
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h04, 32'h000a);
    u_uef_link_model.send(3'h2, 8'h40, 3, 50, k);
    chk("taken_a", 32'h3, k);
    u_uef_link_model.send(3'h2, 8'h80, 2, 50, k);
    chk("taken_b", 32'h2, k);
    rdk(8'h08, 32'h0000_2005, "stat_out");
    fork
      u_uef_link_model.send(3'h2, 8'hc0, 6, 400, k2);
    join_none
    repeat (20) @(negedge CORE_CLK);
    chk("rx_ready", 32'h0, {31'h0, RX_READY});
    for (int i = 0; i < 11; i++) begin
      if (i == 3 || i == 5) apb(1'b1, 8'h10, 32'h1);
      if (i == 5) wait fork;
      apb(1'b0, 8'h0c, 32'h0);
      chk("rxbyte", (i < 3) ? 8'h40 + i : (i < 5) ? 8'h7d + i : 8'hbb + i, rd[7:0]);
    end
    chk("taken_c", 32'h6, k2);
    apb(1'b1, 8'h10, 32'h1);
    rdk(8'h0c, 32'h0, "underflow");
    apb(1'b1, 8'h0c, 32'h55);
    rdk(8'h14, 32'h6, "err");
    apb(1'b1, 8'h14, 32'h7);
    rdk(8'h14, 32'h0, "err_clr");
    $display("test out done");
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    chk("watchdog", 32'h0, 32'h1);
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
